// ---- logic/iks_exec.sv ----
/*
 * Executor for increment-and-skip (zero / nonzero) and literal OR into
 * the accumulator, with quarter sequencing and skip flush.
 * Assumes the fetch unit holds the word in Q1 and that the file
 * register array answers a Q2 read within that quarter.
 */
`timescale 1ns/100ps
`include "iks_cfg.svh"

module iks_exec (
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_i,
    input  wire logic [15:0]           instr_i,
    input  wire logic                  instr_valid_i,
    input  wire logic                  next_two_word_i,
    input  wire logic                  ext_set_en_i,
    input  wire logic [3:0]            bank_select_reg_i,
    input  wire logic [11:0]           index_base_i,
    input  wire logic [7:0]            fr_rdata_i,
    output iks_pkg::iks_quarter_t      quarter_o,
    output logic [11:0]                fr_addr_o,
    output logic                       fr_rd_o,
    output logic                       fr_wr_o,
    output logic [7:0]                 fr_wdata_o,
    output logic [7:0]                 accum_o,
    output logic                       neg_flag_o,
    output logic                       zero_flag_o,
    output logic                       flush_o
);
    import iks_pkg::*;

    iks_quarter_t q_reg;
    iks_quarter_t q_next;
    iks_op_t      op_reg;
    logic [15:0]  instr_reg;
    logic [11:0]  addr_reg;
    logic [7:0]   operand_reg;
    logic [7:0]   result_reg;
    logic [7:0]   w_reg;
    logic         n_reg;
    logic         z_reg;
    logic [1:0]   flush_cnt_reg;
    logic         flushing_reg;
    logic         two_word_reg;
    logic         rd_reg;
    logic         wr_reg;
    logic [7:0]   wdata_reg;

    logic [11:0]  addr_w;
    logic         indexed_w;
    iks_op_t      dec_op;
    logic         op_is_inc;
    logic         dest_file;
    logic         start_exec;
    logic [7:0]   result_next;
    logic         result_zero;
    logic         skip_take;
    logic         w_load;

    // Operand address formed straight from the fetched word
    iks_addr u_addr (
        .file_i            (instr_i[7:0]),
        .bank_bit_i        (instr_i[`IKS_BANK_BIT]),
        .ext_set_en_i      (ext_set_en_i),
        .bank_select_reg_i (bank_select_reg_i),
        .index_base_i      (index_base_i),
        .addr_o            (addr_w),
        .indexed_o         (indexed_w)
    );

    // Decode and datapath terms
    assign dec_op      = instr_valid_i ? iks_decode(instr_i) : IKS_OP_NONE;
    assign start_exec  = (flush_cnt_reg == 2'h0);
    assign op_is_inc   = (op_reg == IKS_OP_INC_SKZ)
                         || (op_reg == IKS_OP_INC_SKNZ);
    assign dest_file   = instr_reg[`IKS_DEST_BIT];
    assign result_next = (op_reg == IKS_OP_OR_LIT)
                         ? (w_reg | operand_reg)
                         : (operand_reg + `IKS_INC_STEP);
    assign result_zero = (result_reg == `IKS_ZERO_BYTE);
    assign skip_take   = ((op_reg == IKS_OP_INC_SKZ) && result_zero)
                         || ((op_reg == IKS_OP_INC_SKNZ)
                             && !result_zero);
    assign w_load      = (op_is_inc && !dest_file)
                         || (op_reg == IKS_OP_OR_LIT);

    // Quarter divider, one quarter per core clock
    always_comb
    begin
        case (q_reg)
            IKS_Q1:  q_next = IKS_Q2;
            IKS_Q2:  q_next = IKS_Q3;
            IKS_Q3:  q_next = IKS_Q4;
            IKS_Q4:  q_next = IKS_Q1;
            default: q_next = IKS_Q1;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            q_reg <= IKS_Q1;
        else
            q_reg <= q_next;
    end

    // Q1: decode, or swallow the fetched word while flushing
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            op_reg        <= IKS_OP_NONE;
            instr_reg     <= 16'h0000;
            addr_reg      <= 12'h000;
            flushing_reg  <= 1'b0;
            two_word_reg  <= 1'b0;
        end
        else if (q_reg == IKS_Q1)
        begin
            flushing_reg <= !start_exec;
            two_word_reg <= next_two_word_i;
            instr_reg    <= instr_i;
            // A flushed word becomes a no-operation cycle
            op_reg       <= start_exec ? dec_op : IKS_OP_NONE;
            addr_reg     <= addr_w;
        end
    end

    // Q2 read strobe; Q4 write strobe. Both stay low in flushed cycles.
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            rd_reg    <= 1'b0;
            wr_reg    <= 1'b0;
            wdata_reg <= 8'h00;
        end
        else
        begin
            rd_reg <= (q_reg == IKS_Q1) && start_exec
                      && ((dec_op == IKS_OP_INC_SKZ)
                          || (dec_op == IKS_OP_INC_SKNZ));
            wr_reg <= (q_reg == IKS_Q3) && op_is_inc && dest_file;
            if (q_reg == IKS_Q3)
                wdata_reg <= result_next;
        end
    end

    // Q2 operand capture, Q3 processing
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            operand_reg <= 8'h00;
            result_reg  <= 8'h00;
        end
        else if (q_reg == IKS_Q2)
            // Literal sits in the low byte of the word
            operand_reg <= op_is_inc ? fr_rdata_i : instr_reg[7:0];
        else if (q_reg == IKS_Q3)
            result_reg <= result_next;
    end

    // Q4: accumulator and flag write-back, skip arming
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            w_reg         <= `IKS_W_RESET;
            n_reg         <= 1'b0;
            z_reg         <= 1'b0;
            flush_cnt_reg <= 2'h0;
        end
        else if (q_reg == IKS_Q4)
        begin
            if (w_load)
                w_reg <= result_reg;
            // Increments leave every flag alone
            if (op_reg == IKS_OP_OR_LIT)
            begin
                n_reg <= result_reg[7];
                z_reg <= result_zero;
            end
            if (skip_take)
                flush_cnt_reg <= two_word_reg ? `IKS_FLUSH_TWO_WORD
                                              : `IKS_FLUSH_ONE_WORD;
            else if (!start_exec)
                flush_cnt_reg <= flush_cnt_reg - 2'h1;
        end
    end

    // Outputs, all from flip-flops
    assign quarter_o   = q_reg;
    assign fr_addr_o   = addr_reg;
    assign fr_rd_o     = rd_reg;
    assign fr_wr_o     = wr_reg;
    assign fr_wdata_o  = wdata_reg;
    assign accum_o     = w_reg;
    assign neg_flag_o  = n_reg;
    assign zero_flag_o = z_reg;
    assign flush_o     = flushing_reg;

    // Checks on the executor
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_skz_decode: assert property (
        (q_reg == IKS_Q1) && start_exec && instr_valid_i
        && (instr_i[15:10] == `IKS_ENC_INC_SKZ)
        |=> (op_reg == IKS_OP_INC_SKZ) && fr_rd_o)
        else $error("skip-if-zero increment not decoded");

    a_sknz_decode: assert property (
        (q_reg == IKS_Q1) && start_exec && instr_valid_i
        && (instr_i[15:10] == `IKS_ENC_INC_SKNZ)
        |=> (op_reg == IKS_OP_INC_SKNZ) && fr_rd_o)
        else $error("skip-if-nonzero increment not decoded");

    a_inc_value: assert property (
        (q_reg == IKS_Q2) && op_is_inc
        |=> ##1 (result_reg == $past(fr_rdata_i, 2) + `IKS_INC_STEP))
        else $error("increment result wrong");

    a_inc_flags_kept: assert property (
        (q_reg == IKS_Q4) && op_is_inc
        |=> $stable(neg_flag_o) && $stable(zero_flag_o))
        else $error("increment touched a flag");

    a_dest_file: assert property (
        (q_reg == IKS_Q3) && op_is_inc && dest_file
        |=> fr_wr_o && (fr_wdata_o == result_reg) ##1 $stable(accum_o))
        else $error("file destination not written");

    a_dest_accum: assert property (
        (q_reg == IKS_Q3) && op_is_inc && !dest_file
        |=> !fr_wr_o ##1 (accum_o == $past(result_reg)))
        else $error("accumulator destination not written");

    a_bank_addr: assert property (
        (q_reg == IKS_Q1) && instr_i[`IKS_BANK_BIT]
        |=> fr_addr_o == {$past(bank_select_reg_i), $past(instr_i[7:0])})
        else $error("banked address wrong");

    a_indexed_addr: assert property (
        (q_reg == IKS_Q1) && ext_set_en_i && !instr_i[`IKS_BANK_BIT]
        && (instr_i[7:0] <= `IKS_INDEXED_LIMIT)
        |=> fr_addr_o == $past(index_base_i) + {4'h0, $past(instr_i[7:0])})
        else $error("indexed address wrong");

    a_skz_flush: assert property (
        (q_reg == IKS_Q4) && (op_reg == IKS_OP_INC_SKZ) && result_zero
        && !two_word_reg
        |-> ##2 (flush_o && !fr_rd_o && !fr_wr_o)[*4] ##1 !flush_o)
        else $error("zero skip did not flush one cycle");

    a_sknz_flush: assert property (
        (q_reg == IKS_Q4) && (op_reg == IKS_OP_INC_SKNZ) && !result_zero
        && !two_word_reg
        |-> ##2 flush_o[*4] ##1 !flush_o)
        else $error("nonzero skip did not flush one cycle");

    a_no_skip: assert property (
        (q_reg == IKS_Q4) && op_is_inc && !skip_take && start_exec
        |-> ##2 !flush_o)
        else $error("flush without a skip");

    a_two_word_flush: assert property (
        (q_reg == IKS_Q4) && skip_take && two_word_reg
        |-> ##2 flush_o[*8] ##1 !flush_o)
        else $error("two-word skip not two flushed cycles");

    a_or_result: assert property (
        (q_reg == IKS_Q3) && (op_reg == IKS_OP_OR_LIT)
        |=> ##1 (accum_o == ($past(w_reg, 2) | $past(instr_reg[7:0], 2))))
        else $error("literal OR result wrong");

    a_or_flags: assert property (
        (q_reg == IKS_Q4) && (op_reg == IKS_OP_OR_LIT)
        |=> (neg_flag_o == accum_o[7])
            && (zero_flag_o == (accum_o == `IKS_ZERO_BYTE)))
        else $error("literal OR flags wrong");

    a_or_no_file: assert property (
        (op_reg == IKS_OP_OR_LIT) |-> !fr_rd_o && !fr_wr_o)
        else $error("literal OR touched the file");

    a_quarter_use: assert property (
        (fr_rd_o |-> q_reg == IKS_Q2) and (fr_wr_o |-> q_reg == IKS_Q4))
        else $error("strobe in the wrong quarter");

endmodule : iks_exec

// ---- logic/iks_cfg.svh ----
/*
 * Encodings, address limits and skip flush lengths for the increment-and-skip
 * and literal-OR executor.
 * Assumes a 16-bit program word and a 12-bit data address space.
 */
`ifndef IKS_CFG_SVH
`define IKS_CFG_SVH

// Opcode fields
`define IKS_ENC_INC_SKZ     6'h0F
`define IKS_ENC_INC_SKNZ    6'h12
`define IKS_ENC_OR_LIT      8'h09
`define IKS_OPC6_HI         15
`define IKS_OPC6_LO         10
`define IKS_OPC8_LO         8
`define IKS_DEST_BIT        9
`define IKS_BANK_BIT        8

// Data addressing
`define IKS_ACCESS_SPLIT    8'h5F
`define IKS_INDEXED_LIMIT   8'h5F
`define IKS_ACCESS_LO_BANK  4'h0
`define IKS_ACCESS_HI_BANK  4'hF

// Skip flush lengths, in instruction cycles
`define IKS_FLUSH_ONE_WORD  2'h1
`define IKS_FLUSH_TWO_WORD  2'h2

// Accumulator reset value, increment step and zero byte
`define IKS_W_RESET         8'h00
`define IKS_INC_STEP        8'h01
`define IKS_ZERO_BYTE       8'h00

`endif

// ---- logic/iks_pkg.sv ----
/*
 * Types and the opcode decoder shared by the executor.
 * Assumes iks_cfg.svh is on the include path.
 */
`include "iks_cfg.svh"

package iks_pkg;

    // Operation carried by the current instruction cycle
    typedef enum logic [1:0] {
        IKS_OP_NONE,
        IKS_OP_INC_SKZ,
        IKS_OP_INC_SKNZ,
        IKS_OP_OR_LIT
    } iks_op_t;

    // Quarter of the instruction cycle
    typedef enum logic [1:0] {
        IKS_Q1,
        IKS_Q2,
        IKS_Q3,
        IKS_Q4
    } iks_quarter_t;

    // Opcode decode, used by the datapath; the checks compare the opcode fields themselves
    function automatic iks_op_t iks_decode(input logic [15:0] word);
        iks_op_t op;
        op = IKS_OP_NONE;
        if (word[`IKS_OPC6_HI:`IKS_OPC6_LO] == `IKS_ENC_INC_SKZ)
            op = IKS_OP_INC_SKZ;
        else if (word[`IKS_OPC6_HI:`IKS_OPC6_LO] == `IKS_ENC_INC_SKNZ)
            op = IKS_OP_INC_SKNZ;
        else if (word[`IKS_OPC6_HI:`IKS_OPC8_LO] == `IKS_ENC_OR_LIT)
            op = IKS_OP_OR_LIT;
        return op;
    endfunction : iks_decode

endpackage : iks_pkg

// ---- logic/iks_addr.sv ----
/*
 * Data address former for file-register operands: access bank, banked
 * or indexed literal offset.
 * Assumes the caller samples the result on its own clock.
 */
`timescale 1ns/100ps
`include "iks_cfg.svh"

module iks_addr (
    input  wire logic [7:0]  file_i,
    input  wire logic        bank_bit_i,
    input  wire logic        ext_set_en_i,
    input  wire logic [3:0]  bank_select_reg_i,
    input  wire logic [11:0] index_base_i,
    output logic      [11:0] addr_o,
    output logic             indexed_o
);
    import iks_pkg::*;

    logic [11:0] access_addr;
    logic [11:0] banked_addr;
    logic [11:0] indexed_addr;

    // Indexed offset only in the low access range with extensions on
    assign indexed_o = ext_set_en_i && !bank_bit_i
                       && (file_i <= `IKS_INDEXED_LIMIT);

    // Access bank splits between bank 0 and the top bank
    assign access_addr = (file_i <= `IKS_ACCESS_SPLIT)
                         ? {`IKS_ACCESS_LO_BANK, file_i}
                         : {`IKS_ACCESS_HI_BANK, file_i};
    assign banked_addr = {bank_select_reg_i, file_i};
    assign indexed_addr = index_base_i + {4'h0, file_i};

    // Selection, indexed first since it overrides the access bank
    assign addr_o = indexed_o  ? indexed_addr
                  : bank_bit_i ? banked_addr
                  : access_addr;

endmodule : iks_addr

// ---- verification/tb_top.sv ----
/*
 * Self-checking bench for the increment-and-skip / literal-OR executor.
 * Assumes iks_pkg and iks_exec are compiled first; inputs change at the
 * falling edge, outputs are compared there once settled.
 */
`timescale 1ns/100ps

module tb_top;
    import iks_pkg::*;

    logic         core_clk_i;
    logic         rst_i;
    logic [15:0]  instr_i;
    logic         instr_valid_i;
    logic         next_two_word_i;
    logic         ext_set_en_i;
    logic [3:0]   bank_select_reg_i;
    logic [11:0]  index_base_i;
    logic [7:0]   fr_rdata_i;
    iks_quarter_t quarter_o;
    logic [11:0]  fr_addr_o;
    logic         fr_rd_o;
    logic         fr_wr_o;
    logic [7:0]   fr_wdata_o;
    logic [7:0]   accum_o;
    logic         neg_flag_o;
    logic         zero_flag_o;
    logic         flush_o;
    int           mismatches;
    int           total_checks;
    logic [7:0]   m_w;
    logic         m_n;
    logic         m_z;
    logic [15:0]  w;
    logic [7:0]   rd;

    iks_exec dut (
        .core_clk_i,
        .rst_i,
        .instr_i,
        .instr_valid_i,
        .next_two_word_i,
        .ext_set_en_i,
        .bank_select_reg_i,
        .index_base_i,
        .fr_rdata_i,
        .quarter_o,
        .fr_addr_o,
        .fr_rd_o,
        .fr_wr_o,
        .fr_wdata_o,
        .accum_o,
        .neg_flag_o,
        .zero_flag_o,
        .flush_o
    );

    // 50 MHz core clock
    initial
    begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Expected operand address, from the bench's own view of the inputs
    function automatic logic [11:0] exp_addr(input logic [7:0] f,
                                             input logic       a);
        if (!a && ext_set_en_i && f <= 8'h5F)
            return index_base_i + {4'h0, f};
        if (a)
            return {bank_select_reg_i, f};
        return {(f <= 8'h5F) ? 4'h0 : 4'hF, f};
    endfunction : exp_addr

    // One discarded cycle; the offered word must be ignored
    task automatic flushed;
        // An OR or a skip-if-zero increment; either must stay dead
        instr_i = {($urandom % 2) ? 8'h09 : 8'h3C, 8'($urandom)};
        instr_valid_i = 1'b1;
        repeat (4)
        begin
            @(negedge core_clk_i);
            chk(12'({flush_o, fr_rd_o, fr_wr_o}), 12'h004);
        end
        chk(12'(accum_o), 12'(m_w));
    endtask : flushed

    // One instruction cycle from Q1 to the next Q1, plus any flush
    task automatic run(input logic [15:0] iw, input logic v,
                       input logic two, input logic [7:0] rdat);
        logic       inc;
        logic       orl;
        logic       d;
        logic       skip;
        logic [7:0] res;
        inc = v && (iw[15:10] == 6'h0F || iw[15:10] == 6'h12);
        orl = v && iw[15:8] == 8'h09;
        d = iw[9];
        res = rdat + 8'h01;
        skip = v && ((iw[15:10] == 6'h0F && res == 8'h00) ||
                     (iw[15:10] == 6'h12 && res != 8'h00));
        chk(12'(quarter_o), 12'(IKS_Q1));
        instr_i = iw;
        instr_valid_i = v;
        next_two_word_i = two;
        @(negedge core_clk_i);
        chk(12'(fr_rd_o), 12'(inc));
        if (inc)
            chk(fr_addr_o, exp_addr(iw[7:0], iw[8]));
        chk(12'(flush_o), 12'h000);
        fr_rdata_i = rdat;
        @(negedge core_clk_i);
        chk(12'({fr_rd_o, fr_wr_o}), 12'h000);
        // Read bus released: show a changed value, not the last one
        fr_rdata_i = ~rdat;
        instr_i = ~iw;
        @(negedge core_clk_i);
        chk(12'(fr_wr_o), 12'(inc & d));
        if (inc & d)
            chk(12'(fr_wdata_o), 12'(res));
        if (inc & !d)
            m_w = res;
        if (orl)
        begin
            m_w = m_w | iw[7:0];
            m_n = m_w[7];
            m_z = (m_w == 8'h00);
        end
        @(negedge core_clk_i);
        chk(12'(accum_o), 12'(m_w));
        chk(12'({neg_flag_o, zero_flag_o}), 12'({m_n, m_z}));
        if (skip)
            repeat (two ? 2 : 1) flushed();
    endtask : run

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // Watchdog, well beyond the roughly 1700 cycles the tests take
    initial
    begin
        #(20000 * 20);
        mismatches++;
        end_of_test();
    end

    initial
    begin
        void'($urandom(32'hd8564f19));
        mismatches = 0;
        total_checks = 0;
        rst_i = 1'b1;
        instr_i = 16'h0000;
        instr_valid_i = 1'b0;
        next_two_word_i = 1'b0;
        ext_set_en_i = 1'b0;
        bank_select_reg_i = 4'h5;
        index_base_i = 12'hFF0;
        fr_rdata_i = 8'h00;
        m_w = 8'h00;
        m_n = 1'b0;
        m_z = 1'b0;
        repeat (12) @(negedge core_clk_i);
        rst_i = 1'b0;
        chk(12'({fr_rd_o, fr_wr_o, flush_o}), 12'h000);
        // Corner cases: boundaries, both skip lengths, refused words
        run(16'h3E10, 1'b1, 1'b0, 8'hFF);
        run(16'h3C5F, 1'b1, 1'b0, 8'h99);
        run(16'h0935, 1'b1, 1'b0, 8'h00);
        run(16'h4B60, 1'b1, 1'b1, 8'h10);
        run(16'h4860, 1'b1, 1'b0, 8'hFF);
        run(16'h0900, 1'b1, 1'b0, 8'h00);
        ext_set_en_i = 1'b1;
        run(16'h3E5F, 1'b1, 1'b0, 8'h01);
        run(16'h3E60, 1'b1, 1'b0, 8'h02);
        run(16'h3F10, 1'b1, 1'b0, 8'h03);
        run(16'h09FF, 1'b0, 1'b0, 8'h00);
        run(16'h2A10, 1'b1, 1'b0, 8'h00);
        run(16'h3C20, 1'b1, 1'b1, 8'hFF);
        $display("test corners done");
        // Random mix; all-ones reads make zero results frequent
        repeat (300)
        begin
            ext_set_en_i = 1'($urandom);
            bank_select_reg_i = 4'($urandom);
            index_base_i = 12'($urandom);
            w = 16'($urandom);
            case ($urandom % 4)
                0: w[15:10] = 6'h0F;
                1: w[15:10] = 6'h12;
                2: w[15:8] = 8'h09;
                default: ;
            endcase
            rd = ($urandom % 4 == 0) ? 8'hFF : 8'($urandom);
            run(w, 1'($urandom % 8 != 0), 1'($urandom), rd);
        end
        $display("test random done");
        // Second reset in mid-run, then one more instruction
        rst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b0;
        m_w = 8'h00;
        m_n = 1'b0;
        m_z = 1'b0;
        chk(12'({accum_o, neg_flag_o, zero_flag_o}), 12'h000);
        run(16'h0981, 1'b1, 1'b0, 8'h00);
        $display("test reset done");
        end_of_test();
    end

endmodule : tb_top
